//--- soj_pkg.sv
// Constants and types for the single-operand and jump executor
package soj_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFF_REG_LIMIT = 8'h40; // R0..R15 below
  localparam logic [7:0] OFF_CTRL = 8'h40;      // Opcode and go
  localparam logic [7:0] OFF_EVENT = 8'h44;     // Entry sequences
  localparam logic [7:0] OFF_STATUS = 8'h48;    // Busy, error, cycles
  localparam int REG_IDX_LSB = 2;               // Word index in address
  localparam int NUM_REGS = 16;                 // Core register count

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_GO = 16;     // Go bit in control word
  localparam int EV_IRQ = 0;       // Interrupt acceptance
  localparam int EV_WATCHDOG = 1;  // Watchdog reset
  localparam int EV_PIN = 2;       // Pin reset
  localparam int STAT_BUSY = 0;    // Sequence running
  localparam int STAT_ILLEGAL = 1; // Last opcode refused
  localparam int STAT_CYC_LSB = 4; // Cycles of last sequence
  localparam int FLAG_C = 0;       // Carry
  localparam int FLAG_Z = 1;       // Zero
  localparam int FLAG_N = 2;       // Negative
  localparam int FLAG_V = 8;       // Overflow
  localparam int OP_AS_LSB = 4;    // Source addressing field
  localparam int OP_AUTOINC = 4;   // Low bit of addressing field
  localparam int OP_BW = 6;        // Byte operation bit
  localparam int OP_F2_LSB = 7;    // Single-operand opcode
  localparam int OP_COND_LSB = 10; // Jump condition

  // ************************************************************
  // Register numbers and opcode patterns
  // ************************************************************
  localparam logic [3:0] RN_PC = 4'h0;   // Program counter
  localparam logic [3:0] RN_STK = 4'h1;  // Stack pointer
  localparam logic [3:0] RN_STAT = 4'h2; // Status register
  localparam logic [5:0] F2_PREFIX = 6'h04;
  localparam logic [2:0] JUMP_PREFIX = 3'h1;
  localparam logic [2:0] F2_UNUSED = 3'h7;
  localparam logic [15:0] OPC_SUB_RETURN = 16'h4130;
  localparam logic [19:0] WORD_STEP = 20'h00002;
  localparam logic [19:0] BYTE_STEP = 20'h00001;

  // ************************************************************
  // Cycle counts in system clock periods
  // ************************************************************
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_SUB_RETURN = 3'h3;
  localparam logic [2:0] CYC_INT_RETURN = 3'h3;
  localparam logic [2:0] CYC_IRQ = 3'h5;
  localparam logic [2:0] CYC_RESET = 3'h4;
  localparam logic [2:0] CYC_ROT_REG = 3'h1;
  localparam logic [2:0] CYC_IND = 3'h3;
  localparam logic [2:0] CYC_STK_REG = 3'h3;
  localparam logic [2:0] CYC_CALL_IND = 3'h4;
  localparam logic [2:0] CYC_IDX = 3'h4;
  localparam logic [2:0] CYC_STK_IDX = 3'h5;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    F2_ROT_CARRY, F2_BYTE_SWAP, F2_ASHR, F2_SIGN_EXT,
    F2_PUSH, F2_CALL, F2_INT_RETURN
  } soj_f2op_t;
  typedef enum logic [2:0] {
    BR_NOT_ZERO, BR_ZERO, BR_NO_CARRY, BR_CARRY,
    BR_NEG, BR_GE, BR_LT, BR_ALWAYS
  } soj_bcond_t;
  typedef enum logic [1:0] {AM_REG, AM_IND, AM_IMM, AM_IDX} soj_amode_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_EXT, ST_OPND, ST_POP_STAT, ST_POP_PC,
    ST_IRQ_STAT, ST_IRQ_VEC, ST_VEC, ST_PAD
  } soj_state_t;
  typedef struct packed {
    logic rd;            // Read strobe
    logic wr;            // Write strobe
    logic byte_op;       // Byte access, data in low byte
    logic [19:0] addr;   // Byte address
    logic [15:0] wdata;  // Write data
  } soj_mem_req_t;

endpackage

//--- soj_exec.sv
// Single-operand and jump instruction executor with register slave
`timescale 1ns/1ps

// What this block does
// - Indexed, symbolic, absolute, immediate fetch extra word
// - Rotate right through carry, update flags
// - Arithmetic shift keeps sign, clears overflow
// - Push decrements stack by two, then writes
// - Byte swap exchanges halves, flags untouched
// - Sign extend bit seven, register mode twenty bits
// - Call reaches lower 64 KB, flags untouched
// - Interrupt return pops status, then counter
// - Jump adds doubled signed offset to counter
// - Jumps never change status flags
// - Zero, not zero, carry, no carry, negative
// - Signed ge, signed lt, always
// - Every jump takes two cycles
// - Cycles follow format, addressing mode and stack base register only
// - Cycles counted on the system clock
// - Interrupt return takes three cycles
// - Subroutine return takes three cycles
// - Interrupt entry five, resets four cycles
// - Single-operand cycle table per addressing mode
// - Stack-indexed push or call takes five
module soj_exec
  import soj_pkg::*;
#(
  parameter logic [19:0] RESET_VEC = 20'h0fffe, // Reset vector address
  parameter logic [19:0] IRQ_VEC = 20'h0fff0    // Interrupt vector address
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program and data memory
  output soj_mem_req_t mem_req,
  input wire logic [15:0] mem_rdata,
  // Sequence status
  output logic exec_busy,
  output logic exec_done
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Negative and zero of a byte or word result
  function automatic logic [1:0] nz_of(logic [15:0] r, logic b);
    logic [1:0] f;
    f[1] = b ? r[7] : r[15];
    f[0] = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
    return f;
  endfunction

  // Cycle count from format, addressing mode and stack base register
  function automatic logic [2:0] f2_cycles(soj_f2op_t k,
                                           soj_amode_t m,
                                           logic stk_base);
    logic [2:0] c;
    logic stk;
    stk = (k == F2_PUSH) || (k == F2_CALL);
    c = CYC_IDX;
    unique case (m)
      AM_REG: c = stk ? CYC_STK_REG : CYC_ROT_REG;
      AM_IND, AM_IMM:
        c = (k == F2_CALL) ? CYC_CALL_IND : CYC_IND;
      AM_IDX: c = (stk && stk_base) ? CYC_STK_IDX : CYC_IDX;
    endcase
    return c;
  endfunction

  // Branch condition from the status flags
  function automatic logic jump_taken(logic [2:0] cc,
                                      logic [19:0] st);
    logic t;
    t = 1'b1;
    unique case (soj_bcond_t'(cc))
      BR_NOT_ZERO: t = ~st[FLAG_Z];
      BR_ZERO: t = st[FLAG_Z];
      BR_NO_CARRY: t = ~st[FLAG_C];
      BR_CARRY: t = st[FLAG_C];
      BR_NEG: t = st[FLAG_N];
      BR_GE: t = ~(st[FLAG_N] ^ st[FLAG_V]);
      BR_LT: t = st[FLAG_N] ^ st[FLAG_V];
      BR_ALWAYS: t = 1'b1;
    endcase
    return t;
  endfunction

  // Byte-lane merge for bus writes
  function automatic logic [31:0] be_merge(logic [31:0] o,
                                           logic [31:0] n,
                                           logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [19:0] regs [NUM_REGS];      // Core registers
  logic [19:0] next_regs [NUM_REGS];
  soj_state_t state, next_state;     // Sequencer state
  logic [2:0] cnt, next_cnt;         // Cycle within sequence
  logic [2:0] total, next_total;     // Cycles of sequence
  logic [15:0] op, next_op;          // Last opcode
  soj_f2op_t f2, next_f2;            // Latched operation
  soj_amode_t amode, next_amode;     // Latched mode
  logic [3:0] rn, next_rn;           // Operand register
  logic bw, next_bw;                 // Byte operation
  logic from_mem, next_from_mem;     // Operand comes from memory
  logic [19:0] opnd, next_opnd;      // Held operand
  logic [19:0] ea, next_ea;          // Base, then operand address
  logic illegal, next_illegal;       // Refused opcode
  soj_mem_req_t next_mem;            // Memory request
  logic next_busy, next_done;
  logic [31:0] next_rdata;
  logic next_wait;
  logic wr_acc;                      // Write completes this edge
  logic last;                        // Final cycle of sequence
  logic idle;

  assign wr_acc = avs_write && !avs_waitrequest;
  assign last = (cnt == (total - 3'h1));
  assign idle = (state == ST_IDLE);

  // ************************************************************
  // Avalon slave: one wait cycle, then answer
  // ************************************************************

  // Wait state and read multiplexer
  always_comb
  begin
    next_wait = 1'b1;
    next_rdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest)
    begin
      // Release for exactly one cycle
      next_wait = 1'b0;
      next_rdata = '0;
      if (avs_address[1:0] != 2'b00)
        next_rdata = '0;
      else if (avs_address < OFF_REG_LIMIT)
        next_rdata[19:0] = regs[avs_address[REG_IDX_LSB +: 4]];
      else if (avs_address == OFF_CTRL)
        next_rdata[15:0] = op;
      else if (avs_address == OFF_STATUS)
      begin
        next_rdata[STAT_BUSY] = !idle;
        next_rdata[STAT_ILLEGAL] = illegal;
        next_rdata[STAT_CYC_LSB +: 3] = total;
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else
    begin
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
    end
  end

  // ************************************************************
  // Execution sequencer
  // ************************************************************

  // Next state, registers and memory request
  always_comb
  begin
    logic [15:0] val;
    logic [15:0] res;
    logic [19:0] stk_m2;
    logic [19:0] st;
    logic [15:0] op_in;
    logic [1:0] nzf;
    logic msb;
    logic fin;
    soj_f2op_t k;
    soj_amode_t m;
    logic [3:0] r;
    val = '0;
    res = '0;
    stk_m2 = regs[RN_STK] - WORD_STEP;
    st = regs[RN_STAT];
    op_in = avs_writedata[15:0];
    nzf = '0;
    msb = 1'b0;
    fin = 1'b0;
    k = soj_f2op_t'(op_in[OP_F2_LSB +: 3]);
    r = op_in[3:0];
    m = AM_REG;
    next_regs = regs;
    next_state = state;
    next_cnt = cnt + 3'h1;
    next_total = total;
    next_op = op;
    next_f2 = f2;
    next_amode = amode;
    next_rn = rn;
    next_bw = bw;
    next_from_mem = from_mem;
    next_opnd = opnd;
    next_ea = ea;
    next_illegal = illegal;
    next_mem = '0;
    // Decode addressing field of incoming opcode
    unique case (op_in[OP_AS_LSB +: 2])
      2'b00: m = AM_REG;
      2'b01: m = AM_IDX;
      2'b10: m = AM_IND;
      2'b11: m = (r == RN_PC) ? AM_IMM : AM_IND;
    endcase
    unique case (state)
      ST_IDLE:
      begin
        next_cnt = '0;
        // Register writes from the bus only while idle
        if (wr_acc && avs_address < OFF_REG_LIMIT &&
            avs_address[1:0] == 2'b00)
        begin
          next_regs[avs_address[REG_IDX_LSB +: 4]] = 20'(be_merge(
            {12'h000, regs[avs_address[REG_IDX_LSB +: 4]]},
            avs_writedata, avs_byteenable));
        end
        // Reset and interrupt entry sequences
        if (wr_acc && avs_address == OFF_EVENT &&
            avs_writedata[2:0] != 3'h0)
        begin
          next_illegal = 1'b0;
          if (avs_writedata[EV_PIN] || avs_writedata[EV_WATCHDOG])
          begin
            next_total = CYC_RESET;
            next_regs[RN_STAT] = '0;
            next_mem.rd = 1'b1;
            next_mem.addr = RESET_VEC;
            next_state = ST_VEC;
          end
          else
          begin
            next_total = CYC_IRQ;
            next_mem.wr = 1'b1;
            next_mem.addr = stk_m2;
            next_mem.wdata = regs[RN_PC][15:0];
            next_regs[RN_STK] = stk_m2;
            next_state = ST_IRQ_STAT;
          end
        end
        // Instruction start
        else if (wr_acc && avs_address == OFF_CTRL &&
                 avs_writedata[CTRL_GO])
        begin
          next_op = op_in;
          next_illegal = 1'b0;
          if (op_in == OPC_SUB_RETURN)
          begin
            next_total = CYC_SUB_RETURN;
            next_mem.rd = 1'b1;
            next_mem.addr = regs[RN_STK];
            next_state = ST_POP_PC;
          end
          else if (op_in[15:13] == JUMP_PREFIX)
          begin
            // Flags are left alone on every jump
            next_total = CYC_JUMP;
            if (jump_taken(op_in[OP_COND_LSB +: 3], st))
              next_regs[RN_PC] = regs[RN_PC] +
                {{9{op_in[9]}}, op_in[9:0], 1'b0};
            next_state = ST_PAD;
          end
          else if (op_in[15:10] != F2_PREFIX ||
                   op_in[OP_F2_LSB +: 3] == F2_UNUSED)
            next_illegal = 1'b1;
          else if (k == F2_INT_RETURN)
          begin
            next_total = CYC_INT_RETURN;
            next_mem.rd = 1'b1;
            next_mem.addr = regs[RN_STK];
            next_state = ST_POP_STAT;
          end
          else if (m == AM_IMM && k != F2_PUSH && k != F2_CALL)
            next_illegal = 1'b1;
          else
          begin
            // Count fixed by format, mode and stack base register
            next_total = f2_cycles(k, m, r == RN_STK);
            next_f2 = k;
            next_amode = m;
            next_rn = r;
            next_bw = op_in[OP_BW];
            next_from_mem = (m == AM_IND);
            next_opnd = regs[r];
            next_ea = (r == RN_STAT) ? 20'h00000 : regs[r];
            if (m == AM_IMM || m == AM_IDX)
            begin
              // Fetch the extra word after the opcode
              next_mem.rd = 1'b1;
              next_mem.addr = regs[RN_PC];
              next_regs[RN_PC] = regs[RN_PC] + WORD_STEP;
              next_state = ST_EXT;
            end
            else
            begin
              if (m == AM_IND)
              begin
                next_mem.rd = 1'b1;
                next_mem.addr = regs[r];
                next_mem.byte_op = op_in[OP_BW];
                if (op_in[OP_AUTOINC])
                  next_regs[r] = regs[r] +
                    (op_in[OP_BW] ? BYTE_STEP : WORD_STEP);
              end
              next_state = ST_OPND;
            end
          end
        end
      end
      ST_EXT:
      begin
        // Immediate value or operand address from extra word
        if (amode == AM_IMM)
        begin
          next_opnd = {4'h0, mem_rdata};
          next_from_mem = 1'b0;
        end
        else
        begin
          next_ea = ea + {{4{mem_rdata[15]}}, mem_rdata};
          next_mem.rd = 1'b1;
          next_mem.addr = next_ea;
          next_mem.byte_op = bw;
          next_from_mem = 1'b1;
        end
        next_state = ST_OPND;
      end
      ST_OPND:
      begin
        val = from_mem ? mem_rdata : opnd[15:0];
        fin = 1'b1;
        if (f2 == F2_PUSH)
        begin
          // Stack first moves down, then takes the operand
          next_mem.wr = 1'b1;
          next_mem.addr = stk_m2;
          next_mem.wdata = val;
          next_mem.byte_op = bw;
          next_regs[RN_STK] = stk_m2;
        end
        else if (f2 == F2_CALL)
        begin
          // Return address pushed, target kept below 64 KB
          next_mem.wr = 1'b1;
          next_mem.addr = stk_m2;
          next_mem.wdata = regs[RN_PC][15:0];
          next_regs[RN_STK] = stk_m2;
          next_regs[RN_PC] = {4'h0, val};
        end
        else
        begin
          msb = bw ? val[7] : val[15];
          if (f2 == F2_ROT_CARRY)
            res = bw ? {8'h00, st[FLAG_C], val[7:1]}
                     : {st[FLAG_C], val[15:1]};
          else if (f2 == F2_ASHR)
            res = bw ? {8'h00, val[7], val[7:1]}
                     : {val[15], val[15:1]};
          else if (f2 == F2_BYTE_SWAP)
            res = {val[7:0], val[15:8]};
          else
            res = {{8{val[7]}}, val[7:0]};
          nzf = nz_of(res, bw && f2 != F2_SIGN_EXT);
          // Swap keeps every flag
          if (f2 != F2_BYTE_SWAP)
          begin
            next_regs[RN_STAT][FLAG_N] = nzf[1];
            next_regs[RN_STAT][FLAG_Z] = nzf[0];
            // Overflow only from rotate, else cleared
            next_regs[RN_STAT][FLAG_V] =
              (f2 == F2_ROT_CARRY) ? (~msb & st[FLAG_C]) : 1'b0;
            // Carry from shifted-out bit or nonzero result
            next_regs[RN_STAT][FLAG_C] =
              (f2 == F2_SIGN_EXT) ? ~nzf[0] : val[0];
          end
          if (amode == AM_REG)
          begin
            // Register result, sign to bit 19 for extend
            if (f2 == F2_SIGN_EXT)
              next_regs[rn] = {{12{val[7]}}, val[7:0]};
            else
              next_regs[rn] = {4'h0, res};
          end
          else
          begin
            next_mem.wr = 1'b1;
            next_mem.addr = ea;
            next_mem.wdata = res;
            next_mem.byte_op = bw && f2 != F2_SIGN_EXT;
          end
        end
      end
      ST_POP_STAT:
      begin
        // Status from top word, then counter from the next
        next_regs[RN_STAT] = {4'h0, mem_rdata};
        next_regs[RN_STK] = regs[RN_STK] + WORD_STEP;
        next_mem.rd = 1'b1;
        next_mem.addr = regs[RN_STK] + WORD_STEP;
        next_state = ST_POP_PC;
      end
      ST_POP_PC:
      begin
        next_regs[RN_PC] = {4'h0, mem_rdata};
        next_regs[RN_STK] = regs[RN_STK] + WORD_STEP;
        fin = 1'b1;
      end
      ST_IRQ_STAT:
      begin
        // Save status below the return address
        next_mem.wr = 1'b1;
        next_mem.addr = stk_m2;
        next_mem.wdata = st[15:0];
        next_regs[RN_STK] = stk_m2;
        next_regs[RN_STAT] = '0;
        next_state = ST_IRQ_VEC;
      end
      ST_IRQ_VEC:
      begin
        next_mem.rd = 1'b1;
        next_mem.addr = IRQ_VEC;
        next_state = ST_VEC;
      end
      ST_VEC:
      begin
        next_regs[RN_PC] = {4'h0, mem_rdata};
        fin = 1'b1;
      end
      ST_PAD:
        fin = 1'b0;
    endcase
    // Hold until the counted cycles are used up
    if (!idle && (fin || state == ST_PAD))
      next_state = last ? ST_IDLE : ST_PAD;
    next_busy = (next_state != ST_IDLE);
    next_done = !idle && (next_state == ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      total <= '0;
      op <= '0;
      f2 <= F2_ROT_CARRY;
      amode <= AM_REG;
      rn <= '0;
      bw <= 1'b0;
      from_mem <= 1'b0;
      opnd <= '0;
      ea <= '0;
      illegal <= 1'b0;
      mem_req <= '0;
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      total <= next_total;
      op <= next_op;
      f2 <= next_f2;
      amode <= next_amode;
      rn <= next_rn;
      bw <= next_bw;
      from_mem <= next_from_mem;
      opnd <= next_opnd;
      ea <= next_ea;
      illegal <= next_illegal;
      mem_req <= next_mem;
      exec_busy <= next_busy;
      exec_done <= next_done;
      regs <= next_regs;
    end
  end

endmodule

//--- soj_exec_sva.sv
// Timing checker for the executor
`timescale 1ns/1ps
module soj_exec_sva
  import soj_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched ports
  input wire logic [7:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire soj_mem_req_t mem_req,
  input wire logic exec_busy,
  input wire logic exec_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic acc; // Idle write completing
  logic go; // Opcode launch
  logic [15:0] op; // Launched opcode
  logic f2; // Single-operand group
  logic ev; // Event write
  assign acc = avs_write && !avs_waitrequest && !exec_busy;
  assign go = acc && avs_address == OFF_CTRL && avs_writedata[CTRL_GO];
  assign op = avs_writedata[15:0];
  assign f2 = op[15:10] == F2_PREFIX;
  assign ev = acc && avs_address == OFF_EVENT;
  property p_jump;
    go && op[15:13] == JUMP_PREFIX |=> exec_busy[*2] ##1 exec_done;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump length");
  property p_jnowr;
    go && op[15:13] == JUMP_PREFIX |=> !mem_req.wr[*3];
  endproperty
  a_jnowr: assert property (p_jnowr)
    else $error("jump wrote memory");
  property p_iret;
    go && f2 && op[9:7] == F2_INT_RETURN |=> exec_busy[*3] ##1 exec_done;
  endproperty
  a_iret: assert property (p_iret)
    else $error("int return length");
  property p_sret;
    go && op == OPC_SUB_RETURN |=> exec_busy[*3] ##1 exec_done;
  endproperty
  a_sret: assert property (p_sret)
    else $error("return length");
  property p_irq;
    ev && avs_writedata[2:0] == 3'h1 |=> exec_busy[*5] ##1 exec_done;
  endproperty
  a_irq: assert property (p_irq)
    else $error("entry length");
  property p_rst;
    ev && avs_writedata[2:1] != 2'h0 |=> exec_busy[*4] ##1 exec_done;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset length");
  property p_reg1;
    go && f2 && !op[9] && !op[6] && op[5:4] == AM_REG
      |=> exec_busy ##1 (exec_done && !exec_busy);
  endproperty
  a_reg1: assert property (p_reg1)
    else $error("register op length");
  property p_stk;
    go && f2 && op[9:8] == 2'h2 && op[5:4] == 2'h1 && op[3:0] == RN_STK
      |=> exec_busy[*5] ##1 exec_done;
  endproperty
  a_stk: assert property (p_stk)
    else $error("stack index length");
endmodule

bind soj_exec soj_exec_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
  .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .mem_req(mem_req), .exec_busy(exec_busy), .exec_done(exec_done));

//--- soj_mem.sv
// Memory model on the far side of the executor
`timescale 1ns/1ps
module soj_mem
  import soj_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Memory bus
  input wire soj_mem_req_t mem_req,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [256]; // Words by address bits 8:1
  logic [15:0] junk = 16'h5a5a; // Idle pattern, flips each cycle
  logic [15:0] w; // Addressed word
  assign w = mem[mem_req.addr[8:1]];
  // Same-cycle answer; an idle bus shows no stale data
  assign mem_rdata = !mem_req.rd ? junk : !mem_req.byte_op ? w :
    {8'h00, mem_req.addr[0] ? w[15:8] : w[7:0]};
  // Writes land at the edge, byte lane by address bit 0
  always @(posedge clk_sys)
  begin
    junk <= ~junk;
    if (mem_req.wr && !mem_req.byte_op)
      mem[mem_req.addr[8:1]] <= mem_req.wdata;
    else if (mem_req.wr)
      mem[mem_req.addr[8:1]][mem_req.addr[0]*8+:8] <= mem_req.wdata[7:0];
  end
endmodule

//--- tb.sv
// Self-checking bench for the executor
`timescale 1ns/1ps
module tb;
  import soj_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, exec_busy, exec_done, t;
  soj_mem_req_t mem_req;
  logic [15:0] mem_rdata;
  logic [19:0] v, s, p; // Operand, status, expected
  logic [9:0] o; // Jump offset
  int mismatches = 0, checks = 0, cyc = 0, n = 0;
  soj_exec u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .exec_busy(exec_busy),
    .exec_done(exec_done));
  soj_mem u_mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_rdata(mem_rdata));
  always #5 clk_sys = ~clk_sys;
  // Busy cycle count and hang limit
  always @(posedge clk_sys)
  begin
    if (exec_busy === 1'b1)
      n++;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, a, e);
    end
  endtask
  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input int i, input logic [19:0] d);
    bus(1'h1, 8'(4 * i), {12'h0, d});
  endtask
  task automatic rc(input int i, input logic [19:0] e);
    bus(1'h0, 8'(4 * i), 32'h0);
    chk(q, {12'h0, e});
  endtask
  // Launch a sequence, count busy cycles
  task automatic run(input logic [7:0] a, input logic [31:0] d, input int e);
    n = 0;
    bus(1'h1, a, d);
    for (int k = 0; k < 20 && exec_done !== 1'b1; k++)
      @(posedge clk_sys);
    chk(n, e);
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(q[6:4], e);
  endtask
  initial
  begin
    void'($urandom(32'h30ea));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 19; i++)
      rc(i, 20'h0);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      v = 20'($urandom) & 20'h0ffff;
      s = 20'($urandom) & 20'h00107;
      wr(4, v);
      wr(2, s);
      run(OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 3'(i % 4), 7'h04}, 1);
      case (i % 4)
        0: p = {4'h0, s[FLAG_C], v[15:1]};
        1: p = {4'h0, v[7:0], v[15:8]};
        2: p = {4'h0, v[15], v[15:1]};
        default: p = {{12{v[7]}}, v[7:0]};
      endcase
      if (i % 4 != 1)
        s = {11'h0, i % 4 == 0 && !v[15] && s[0], 5'h0, p[15],
          p[15:0] == 16'h0, i % 4 == 3 ? p[15:0] != 16'h0 : v[0]};
      rc(4, p);
      rc(2, s);
    end
    $display("register ops done");
    for (int c = 0; c < 16; c++)
    begin
      s = 20'($urandom) & 20'h00107;
      p = 20'($urandom) & 20'hffffe;
      o = c > 7 ? 10'h1ff : 10'h200;
      wr(2, s);
      wr(0, p);
      run(OFF_CTRL, {15'h0, 1'b1, JUMP_PREFIX, 3'(c), o}, 2);
      case (c % 8)
        0: t = !s[1];
        1: t = s[1];
        2: t = !s[0];
        3: t = s[0];
        4: t = s[2];
        5: t = s[2] == s[8];
        6: t = s[2] != s[8];
        default: t = 1'b1;
      endcase
      rc(0, t ? p + {{9{o[9]}}, o, 1'b0} : p);
      rc(2, s);
    end
    $display("jumps done");
    v = 20'($urandom) & 20'h0fffe;
    wr(5, v);
    wr(6, v);
    wr(1, 20'h00100);
    wr(0, 20'h00040);
    u_mem.mem[8'h20] = 16'h0002;
    u_mem.mem[8'h80] = v[15:0];
    run(OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 10'h205}, 3);
    rc(1, 20'h000fe);
    chk({16'h0, u_mem.mem[8'h7f]}, {12'h0, v});
    run(OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 10'h211}, 5);
    rc(0, 20'h00042);
    chk({16'h0, u_mem.mem[8'h7e]}, {12'h0, v});
    run(OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 10'h286}, 3);
    rc(0, v);
    chk({16'h0, u_mem.mem[8'h7d]}, 32'h42);
    run(OFF_CTRL, {15'h0, 1'b1, OPC_SUB_RETURN}, 3);
    rc(0, 20'h00042);
    $display("stack ops done");
    wr(2, s);
    u_mem.mem[8'hf8] = 16'h3000;
    run(OFF_EVENT, 32'h1, 5);
    rc(0, 20'h03000);
    run(OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 10'h300}, 3);
    rc(2, s);
    rc(0, 20'h00042);
    rc(1, 20'h000fc);
    u_mem.mem[8'hff] = 16'h4400;
    for (int e = 1; e < 3; e++)
    begin
      run(OFF_EVENT, 32'(1 << e), 4);
      rc(0, 20'h04400);
    end
    bus(1'h1, OFF_CTRL, {15'h0, 1'b1, F2_PREFIX, 10'h030});
    bus(1'h0, OFF_STATUS, 32'h0);
    chk(q[1:0], 2'h2);
    $display("events done");
    close_out();
  end
endmodule
